// >>> rtl/itu_pkg.sv
package itu_pkg;

  // ****************************************
  // Sources and vectors
  // ****************************************
  localparam int N_SRC = 15;
  localparam int SRC_W = 4;
  localparam logic [SRC_W-1:0] SRC_INT_A = 4'h0;
  localparam logic [SRC_W-1:0] SRC_INT_B = 4'h1;
  localparam logic [SRC_W-1:0] SRC_RX = 4'h2;
  localparam logic [SRC_W-1:0] SRC_TX = 4'h3;
  localparam logic [SRC_W-1:0] SRC_TX_TIM = 4'h4;
  localparam logic [SRC_W-1:0] SRC_TY_TIM = 4'h5;
  localparam logic [SRC_W-1:0] SRC_T1 = 4'h6;
  localparam logic [SRC_W-1:0] SRC_T2 = 4'h7;
  localparam logic [SRC_W-1:0] SRC_CNT_A = 4'h8;
  localparam logic [SRC_W-1:0] SRC_CNT_B = 4'h9;
  localparam logic [SRC_W-1:0] SRC_INT_C = 4'hA;
  localparam logic [SRC_W-1:0] SRC_SW_BREAK = 4'hE;
  localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
  localparam logic [15:0] VEC_FIRST_LO = 16'hFFFA;
  localparam logic [15:0] VEC_SW_BREAK_LO = 16'hFFDC;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_EN = 8'h04;
  localparam logic [7:0] OFF_EDGE = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_XY = 8'h10;
  localparam logic [7:0] OFF_PRE12 = 8'h14;
  localparam logic [7:0] OFF_T1 = 8'h18;
  localparam logic [7:0] OFF_T2 = 8'h1C;
  localparam logic [7:0] OFF_PREX = 8'h20;
  localparam logic [7:0] OFF_TX = 8'h24;
  localparam logic [7:0] OFF_PREY = 8'h28;
  localparam logic [7:0] OFF_TY = 8'h2C;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] RST_PRE = 8'hFF;
  localparam logic [7:0] RST_T1 = 8'h01;
  localparam logic [7:0] RST_TIM = 8'hFF;
  localparam logic RST_MASK = 1'b1;
  localparam int OSC_DIV = 16;
  localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_PULSE = 2'h1,
    MODE_EVENT = 2'h2,
    MODE_PWM = 2'h3
  } tmode_t;

  typedef struct packed {
    logic stop;
    logic edge_fall;
    tmode_t mode;
  } tctl_t;

  typedef struct packed {
    tctl_t y;
    tctl_t x;
  } xy_mode_t;

  typedef enum logic [2:0] {
    ST_RST = 3'b001,
    ST_IDLE = 3'b010,
    ST_OFFER = 3'b100
  } arb_st_t;

endpackage

// >>> rtl/interrupt_and_timer_unit.sv
// Overview of operation
// - Maskable source taken only if request 1, enable 1, mask flag 0.
// - Software sets/clears enables; clears requests; writing 1 to request does nothing.
// - Software break is never masked; mask flag blocks all other sources.
// - Acceptance pushes PC and status, then sets the mask flag.
// - Acceptance clears the taken request and loads its two-byte vector.
// - Fifteen sources: eight edge pins, six internal events, one break.
// - Reset is the top, unmaskable vectored event at FFFD/FFFC.
// - Priorities 2..16 in fixed order, vectors FFFB/FFFA down to FFDD/FFDC.
// - Edge and counter pins request on the edge picked by their select bit.
// - Serial receive/transmit events request only while serial I/O is selected.
// - Timers count down; pulse after 00 underflows, reloads, keeps counting.
// - Every timer underflow sets that timer's request bit.
// - Each timer and prescaler divides by latch value plus one.
// - Shared prescaler counts oscillator/16 and clocks timers 1 and 2.
// - Timers X and Y each pick one of four modes.
// - Timer mode counts oscillator/16.
// - Pulse mode toggles counter pin at 00; starts high if edge bit 0.
// - Event mode counts counter pin edges instead of oscillator/16.
// - Width mode counts oscillator/16 while pin high (bit 0) or low (bit 1).
// - Count stop bit halts timer X or Y in any mode.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module interrupt_and_timer_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_edge_in_a,
  input wire logic ext_edge_in_b,
  input wire logic ext_edge_in_c,
  input wire logic ext_edge_in_d,
  input wire logic ext_edge_in_e,
  input wire logic ext_edge_in_f,
  input wire logic counter_pin_a_i,
  output logic counter_pin_a_o,
  output logic counter_pin_a_oe_n,
  input wire logic counter_pin_b_i,
  output logic counter_pin_b_o,
  output logic counter_pin_b_oe_n,
  input wire logic serial_sel,
  input wire logic rx_done,
  input wire logic tx_shift_done,
  input wire logic tx_buf_empty,
  input wire logic software_break_op,
  input wire logic core_ack,
  output logic int_req,
  output logic [15:0] vec_lo_addr,
  output logic [15:0] vec_hi_addr,
  output logic push_state,
  output logic mask_flag
);
  import itu_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic hit_d;
  logic wr, xfer;
  logic [N_SRC-1:0] req_q, en_q, src_set, elig;
  logic [5:0] edge_q;
  logic mask_q;
  xy_mode_t xy_q;
  logic [7:0] pre_lat_q [3];
  logic [7:0] pre_cnt_q [3];
  logic [7:0] tim_lat_q [4];
  logic [7:0] tim_cnt_q [4];

  function automatic logic [7:0] wr_pre(input logic [7:0] a);
    case (a)
      OFF_PRE12: wr_pre = 8'h01;
      OFF_PREX: wr_pre = 8'h02;
      OFF_PREY: wr_pre = 8'h04;
      OFF_T1: wr_pre = 8'h10;
      OFF_T2: wr_pre = 8'h20;
      OFF_TX: wr_pre = 8'h40;
      OFF_TY: wr_pre = 8'h80;
      default: wr_pre = 8'h00;
    endcase
  endfunction

  assign xfer = psel && penable && pready_q;
  assign wr = xfer && pwrite;

  always_comb begin
    rd_d = 32'h0;
    hit_d = 1'b1;
    case (paddr)
      OFF_REQ: rd_d = 32'(req_q);
      OFF_EN: rd_d = 32'(en_q);
      OFF_EDGE: rd_d = 32'(edge_q);
      OFF_STAT: rd_d = 32'(mask_q);
      OFF_XY: rd_d = 32'(xy_q);
      OFF_PRE12: rd_d = 32'(pre_cnt_q[0]);
      OFF_PREX: rd_d = 32'(pre_cnt_q[1]);
      OFF_PREY: rd_d = 32'(pre_cnt_q[2]);
      OFF_T1: rd_d = 32'(tim_cnt_q[0]);
      OFF_T2: rd_d = 32'(tim_cnt_q[1]);
      OFF_TX: rd_d = 32'(tim_cnt_q[2]);
      OFF_TY: rd_d = 32'(tim_cnt_q[3]);
      default: hit_d = 1'b0;
    endcase
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit_d;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_d : 32'h0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= '0;
      edge_q <= '0;
      xy_q <= '0;
    end else if (wr) begin
      if (paddr == OFF_EN) begin
        en_q <= pwdata[N_SRC-1:0];
      end
      if (paddr == OFF_EDGE) begin
        edge_q <= pwdata[5:0];
      end
      if (paddr == OFF_XY) begin
        xy_q <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [7:0] pin_fall_sel, pin_hit;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {counter_pin_b_i, counter_pin_a_i, ext_edge_in_f, ext_edge_in_e,
                   ext_edge_in_d, ext_edge_in_c, ext_edge_in_b, ext_edge_in_a};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_fall_sel = {xy_q.y.edge_fall, xy_q.x.edge_fall, edge_q};

  generate
    for (genvar i = 0; i < 8; i++) begin : g_edge
      assign pin_hit[i] = pin_fall_sel[i] ? (pin_s3_q[i] && !pin_s2_q[i])
                                          : (!pin_s3_q[i] && pin_s2_q[i]);
    end
  endgenerate

  // ****************************************
  // Prescalers and timers
  // ****************************************
  logic [3:0] div_q;
  logic osc_tick;
  logic [2:0] pre_in, pre_uf;
  logic [3:0] tim_in, tim_uf;
  logic [7:0] wsel;
  tctl_t ctl [2];

  // Core clock is the oscillator; divide by 16
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign osc_tick = (div_q == OSC_DIV_LAST);
  assign ctl[0] = xy_q.x;
  assign ctl[1] = xy_q.y;
  assign wsel = wr ? wr_pre(paddr) : 8'h00;
  assign pre_in[0] = osc_tick;

  generate
    for (genvar k = 0; k < 2; k++) begin : g_xy_src
      always_comb begin
        pre_in[k+1] = 1'b0;
        if (!ctl[k].stop) begin
          case (ctl[k].mode)
            MODE_TIMER: pre_in[k+1] = osc_tick;
            MODE_PULSE: pre_in[k+1] = osc_tick;
            MODE_EVENT: pre_in[k+1] = pin_hit[6+k];
            MODE_PWM: pre_in[k+1] = osc_tick && (pin_s2_q[6+k] != ctl[k].edge_fall);
            default: pre_in[k+1] = 1'b0;
          endcase
        end
      end
    end

    for (genvar p = 0; p < 3; p++) begin : g_pre
      assign pre_uf[p] = pre_in[p] && (pre_cnt_q[p] == 8'h00);
      always_ff @(posedge clk) begin
        if (rst) begin
          pre_lat_q[p] <= RST_PRE;
          pre_cnt_q[p] <= RST_PRE;
        end else if (wsel[p]) begin
          pre_lat_q[p] <= pwdata[7:0];
          pre_cnt_q[p] <= pwdata[7:0];
        end else if (pre_uf[p]) begin
          pre_cnt_q[p] <= pre_lat_q[p];
        end else if (pre_in[p]) begin
          pre_cnt_q[p] <= pre_cnt_q[p] - 8'h01;
        end
      end
    end
  endgenerate

  assign tim_in = {pre_uf[2], pre_uf[1], pre_uf[0], pre_uf[0]};

  generate
    for (genvar t = 0; t < 4; t++) begin : g_tim
      assign tim_uf[t] = tim_in[t] && (tim_cnt_q[t] == 8'h00);
      always_ff @(posedge clk) begin
        if (rst) begin
          tim_lat_q[t] <= (t == 0) ? RST_T1 : RST_TIM;
          tim_cnt_q[t] <= (t == 0) ? RST_T1 : RST_TIM;
        end else if (wsel[4+t]) begin
          tim_lat_q[t] <= pwdata[7:0];
          tim_cnt_q[t] <= pwdata[7:0];
        end else if (tim_uf[t]) begin
          tim_cnt_q[t] <= tim_lat_q[t];
        end else if (tim_in[t]) begin
          tim_cnt_q[t] <= tim_cnt_q[t] - 8'h01;
        end
      end
    end
  endgenerate

  // ****************************************
  // Counter pin outputs
  // ****************************************
  logic [1:0] cpo_q, cpoe_n_q;

  // Pin direction is set here: cpoe_n_q goes low to drive the pin only in pulse mode
  generate
    for (genvar k = 0; k < 2; k++) begin : g_cpo
      always_ff @(posedge clk) begin
        if (rst) begin
          cpo_q[k] <= 1'b1;
          cpoe_n_q[k] <= 1'b1;
        end else if (ctl[k].mode != MODE_PULSE) begin
          cpo_q[k] <= !ctl[k].edge_fall;
          cpoe_n_q[k] <= 1'b1;
        end else begin
          cpoe_n_q[k] <= 1'b0;
          // Entry sets the start level: the edge bit may change in that same write
          if (cpoe_n_q[k]) begin
            cpo_q[k] <= !ctl[k].edge_fall;
          end else if (tim_uf[2+k]) begin
            cpo_q[k] <= !cpo_q[k];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Request register
  // ****************************************
  logic [N_SRC-1:0] sw_clr, ack_clr;
  arb_st_t st_q;
  logic [SRC_W-1:0] sel_q;
  logic ack;

  assign ack = (st_q == ST_OFFER) && core_ack;

  always_comb begin
    src_set = '0;
    src_set[SRC_INT_A] = pin_hit[0];
    src_set[SRC_INT_B] = pin_hit[1];
    src_set[SRC_RX] = serial_sel && rx_done;
    src_set[SRC_TX] = serial_sel && (tx_shift_done || tx_buf_empty);
    src_set[SRC_TX_TIM] = tim_uf[2];
    src_set[SRC_TY_TIM] = tim_uf[3];
    src_set[SRC_T1] = tim_uf[0];
    src_set[SRC_T2] = tim_uf[1];
    src_set[SRC_CNT_A] = pin_hit[6];
    src_set[SRC_CNT_B] = pin_hit[7];
    src_set[SRC_INT_C +: 4] = pin_hit[5:2];
    src_set[SRC_SW_BREAK] = software_break_op;
  end

  assign sw_clr = (wr && paddr == OFF_REQ) ? ~pwdata[N_SRC-1:0] : '0;
  assign ack_clr = ack ? N_SRC'(1 << sel_q) : '0;

  // Hardware set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= '0;
    end else begin
      req_q <= (req_q & ~sw_clr & ~ack_clr) | src_set;
    end
  end

  // ****************************************
  // Arbitration and core handshake
  // ****************************************
  logic [SRC_W-1:0] best;
  logic any;

  assign elig[N_SRC-2:0] = req_q[N_SRC-2:0] & en_q[N_SRC-2:0] & {(N_SRC-1){!mask_q}};
  assign elig[SRC_SW_BREAK] = req_q[SRC_SW_BREAK];

  always_comb begin
    best = '0;
    any = 1'b0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        best = SRC_W'(i);
        any = 1'b1;
      end
    end
  end

  function automatic logic [15:0] vec_of(input logic [SRC_W-1:0] s);
    if (s == SRC_SW_BREAK) begin
      vec_of = VEC_SW_BREAK_LO;
    end else begin
      vec_of = VEC_FIRST_LO - {11'h0, s, 1'b0};
    end
  endfunction

  logic int_req_q, push_q;
  logic [15:0] vec_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_RST;
      int_req_q <= 1'b1;
      vec_q <= VEC_RESET_LO;
      sel_q <= '0;
      push_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      case (st_q)
        ST_RST: begin
          if (core_ack) begin
            st_q <= ST_IDLE;
            int_req_q <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (any) begin
            st_q <= ST_OFFER;
            int_req_q <= 1'b1;
            sel_q <= best;
            vec_q <= vec_of(best);
          end
        end
        ST_OFFER: begin
          if (core_ack) begin
            st_q <= ST_IDLE;
            int_req_q <= 1'b0;
            push_q <= 1'b1;
          end else if (any) begin
            sel_q <= best;
            vec_q <= vec_of(best);
          end else begin
            st_q <= ST_IDLE;
            int_req_q <= 1'b0;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          int_req_q <= 1'b0;
        end
      endcase
    end
  end

  // Acceptance is tested before the software write, so it always wins
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= RST_MASK;
    end else if (ack) begin
      mask_q <= 1'b1;
    end else if (wr && paddr == OFF_STAT) begin
      mask_q <= pwdata[0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign counter_pin_a_o = cpo_q[0];
  assign counter_pin_b_o = cpo_q[1];
  assign counter_pin_a_oe_n = cpoe_n_q[0];
  assign counter_pin_b_oe_n = cpoe_n_q[1];
  assign int_req = int_req_q;
  assign vec_lo_addr = vec_q;
  assign vec_hi_addr = vec_q | 16'h0001;
  assign push_state = push_q;
  assign mask_flag = mask_q;

  // ****************************************
  // Checks
  // ****************************************
  mask_blocks_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_OFFER && $past(st_q) == ST_IDLE && sel_q != SRC_SW_BREAK)
    |-> !$past(mask_q))
    else $error("masked source offered");

  accept_push_a: assert property (@(posedge clk) disable iff (rst)
    ack |=> push_state && mask_flag && !int_req)
    else $error("acceptance did not push and mask");

  accept_clear_a: assert property (@(posedge clk) disable iff (rst)
    (ack && !src_set[sel_q]) |=> !req_q[$past(sel_q)])
    else $error("accepted request not cleared");

  no_sw_set_a: assert property (@(posedge clk) disable iff (rst)
    ((req_q & ~$past(req_q) & ~$past(src_set)) == '0))
    else $error("request rose without an event");

  reset_vec_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_RST) |-> (int_req && vec_lo_addr == VEC_RESET_LO))
    else $error("reset vector not offered");

  prio_order_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_OFFER && $past(st_q) == ST_IDLE)
    |-> (($past(elig) & ((N_SRC'(1) << sel_q) - N_SRC'(1))) == '0))
    else $error("lower priority offered first");

  timer_reload_a: assert property (@(posedge clk) disable iff (rst)
    (tim_uf[2] && !wsel[6]) |=> tim_cnt_q[2] == $past(tim_lat_q[2]))
    else $error("timer X did not reload");

  uf_req_a: assert property (@(posedge clk) disable iff (rst)
    tim_uf[0] |=> req_q[SRC_T1])
    else $error("timer 1 underflow lost");

  stop_hold_a: assert property (@(posedge clk) disable iff (rst)
    (xy_q.x.stop && !wsel[1] && !wsel[6]) |=> ($stable(pre_cnt_q[1]) && $stable(tim_cnt_q[2])))
    else $error("stopped timer X counted");

  pulse_tog_a: assert property (@(posedge clk) disable iff (rst)
    (tim_uf[2] && xy_q.x.mode == MODE_PULSE && $past(xy_q.x.mode) == MODE_PULSE)
    |=> counter_pin_a_o != $past(counter_pin_a_o))
    else $error("pulse output did not toggle");

endmodule

`default_nettype wire

// >>> dv/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Core side: accepts offered vectors
// ********
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic int_req,
  input wire logic [15:0] vec_lo_addr,
  input wire logic push_state,
  input wire logic [3:0] ack_delay,
  output logic core_ack,
  output logic [15:0] last_vec,
  output logic last_push,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_q;
  logic pend_q;

  // One ack pulse per offer; the vector is taken at the edge the unit takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      core_ack <= 1'b0;
      wait_q <= 4'h0;
      pend_q <= 1'b0;
      last_vec <= 16'h0000;
      last_push <= 1'b0;
      taken_cnt <= 8'h00;
    end else begin
      core_ack <= 1'b0;
      pend_q <= 1'b0;
      if (core_ack && int_req) begin
        last_vec <= vec_lo_addr;
        pend_q <= 1'b1;
        wait_q <= 4'h0;
      end else if (int_req && !core_ack) begin
        if (wait_q == ack_delay) begin
          core_ack <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
      if (pend_q) begin
        last_push <= push_state;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// >>> dv/interrupt_and_timer_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

module interrupt_and_timer_unit_test;
  import itu_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] ext;
  logic cnt_a, cnt_b, serial_sel, rx_done, tx_shift_done, tx_buf_empty, sw_break;
  logic core_ack, int_req, push_state, mask_flag, last_push;
  logic pa_o, pa_oe_n, pb_o, pb_oe_n, pa_w, pb_w;
  logic [15:0] vec_lo, vec_hi, last_vec;
  logic [7:0] taken_cnt;
  logic [3:0] ack_delay;
  int num_errors, cmp_count, n;
  logic [7:0] ra [9] = '{OFF_REQ, OFF_EN, OFF_EDGE, OFF_STAT, OFF_XY, OFF_T1, OFF_T2, OFF_TX, OFF_TY};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h1, 32'hFF, 32'hFF, 32'hFF};
  int src [6] = '{0, 1, 10, 11, 12, 13};

  // Pin wire: the unit drives it while its enable is low
  assign pa_w = pa_oe_n ? cnt_a : pa_o;
  assign pb_w = pb_oe_n ? cnt_b : pb_o;

  interrupt_and_timer_unit u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_edge_in_a(ext[0]), .ext_edge_in_b(ext[1]), .ext_edge_in_c(ext[2]),
    .ext_edge_in_d(ext[3]), .ext_edge_in_e(ext[4]), .ext_edge_in_f(ext[5]),
    .counter_pin_a_i(pa_w), .counter_pin_a_o(pa_o), .counter_pin_a_oe_n(pa_oe_n),
    .counter_pin_b_i(pb_w), .counter_pin_b_o(pb_o), .counter_pin_b_oe_n(pb_oe_n),
    .serial_sel(serial_sel), .rx_done(rx_done), .tx_shift_done(tx_shift_done),
    .tx_buf_empty(tx_buf_empty), .software_break_op(sw_break), .core_ack(core_ack),
    .int_req(int_req), .vec_lo_addr(vec_lo), .vec_hi_addr(vec_hi),
    .push_state(push_state), .mask_flag(mask_flag)
  );

  core_model u_core (
    .clk(clk), .rst(rst), .int_req(int_req), .vec_lo_addr(vec_lo),
    .push_state(push_state), .ack_delay(ack_delay), .core_ack(core_ack),
    .last_vec(last_vec), .last_push(last_push), .taken_cnt(taken_cnt)
  );

  // ********
  // Tasks
  // ********
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ready is read right after the rising edge, before that edge's updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask

  task automatic take(input logic [15:0] v, input logic p);
    logic [7:0] c0;
    int k;
    @(negedge clk);
    c0 = taken_cnt;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (taken_cnt === c0 && k < 300);
    if (k >= 300) num_errors++;
    check(last_vec, v);
    check(last_push, p);
    check(mask_flag, 1'b1);
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  // ********
  // Sequence
  // ********
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext = 6'h00;
    cnt_a = 1'b0;
    cnt_b = 1'b0;
    serial_sel = 1'b0;
    rx_done = 1'b0;
    tx_shift_done = 1'b0;
    tx_buf_empty = 1'b0;
    sw_break = 1'b0;
    ack_delay = 4'h0;
    num_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(int_req, 1'b1);
    check(vec_lo, VEC_RESET_LO);
    check(vec_hi, 16'hFFFD);
    check({pb_oe_n, pb_o}, 32'h3);
    take(VEC_RESET_LO, 1'b0);
    for (int i = 0; i < 9; i++) begin
      rdc(ra[i], 32'hFFFF, rv[i]);
    end
    apb(1'b0, 8'h30, 32'h0);
    check(err, 1'b1);
    wr(OFF_REQ, 32'h7FFF);
    rdc(OFF_REQ, 32'hFFFF, 32'h0);
    wr(OFF_EN, 32'h7FFF);
    rdc(OFF_EN, 32'hFFFF, 32'h7FFF);
    wr(OFF_EN, 32'h0);
    for (int s = 0; s < 2; s++) begin
      serial_sel <= s[0];
      rx_done <= 1'b1;
      tx_shift_done <= 1'b1;
      @(posedge clk);
      rx_done <= 1'b0;
      tx_shift_done <= 1'b0;
      tx_buf_empty <= 1'b1;
      @(posedge clk);
      tx_buf_empty <= 1'b0;
      rdc(OFF_REQ, 32'hC, s ? 32'hC : 32'h0);
      wr(OFF_REQ, 32'h0);
    end
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
    wr(OFF_STAT, 32'h0);
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(int_req, 1'b0);
    @(posedge clk);
    wr(OFF_EN, 32'h4);
    take(16'hFFF6, 1'b1);
    rdc(OFF_REQ, 32'h4, 32'h0);
    wr(OFF_EN, 32'h0);
    sw_break <= 1'b1;
    @(posedge clk);
    sw_break <= 1'b0;
    take(VEC_SW_BREAK_LO, 1'b1);
    ack_delay <= 4'h6;
    wr(OFF_EN, 32'h3C03);
    ext <= 6'h3F;
    repeat (8) @(posedge clk);
    rdc(OFF_REQ, 32'h7F03, 32'h3C03);
    wr(OFF_STAT, 32'h0);
    for (int k = 0; k < 6; k++) begin
      take(16'hFFFA - 16'(2 * src[k]), 1'b1);
      if (k < 5) wr(OFF_STAT, 32'h0);
    end
    wr(OFF_EN, 32'h0);
    wr(OFF_EDGE, 32'h3F);
    wr(OFF_REQ, 32'h0);
    wr(OFF_EN, 32'h3C03);
    ext <= 6'h00;
    repeat (8) @(posedge clk);
    rdc(OFF_REQ, 32'h3F03, 32'h3C03);
    wr(OFF_EN, 32'h0);
    wr(OFF_XY, 32'h0);
    wr(OFF_PREX, 32'h0);
    wr(OFF_TX, 32'h2);
    wr(OFF_REQ, 32'h0);
    repeat (12) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h0);
    repeat (40) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h10);
    wr(OFF_XY, 32'h08);
    wr(OFF_REQ, 32'h0);
    repeat (80) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h0);
    wr(OFF_PRE12, 32'h1);
    wr(OFF_T1, 32'h0);
    wr(OFF_T2, 32'h0);
    wr(OFF_REQ, 32'h0);
    repeat (60) @(posedge clk);
    rdc(OFF_REQ, 32'hC0, 32'hC0);
    // Pin direction follows the unit's own enable, so no port setup is needed
    wr(OFF_XY, 32'h01);
    @(negedge clk);
    check(pa_oe_n, 1'b0);
    check(pa_o, 1'b1);
    n = 0;
    while (pa_o === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (pa_o === 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'h30);
    @(posedge clk);
    wr(OFF_XY, 32'h0);
    wr(OFF_XY, 32'h05);
    @(negedge clk);
    check(pa_o, 1'b0);
    @(posedge clk);
    wr(OFF_XY, 32'h02);
    wr(OFF_TX, 32'h1);
    wr(OFF_REQ, 32'h0);
    cnt_a <= 1'b1;
    repeat (40) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h0);
    cnt_a <= 1'b0;
    repeat (8) @(posedge clk);
    cnt_a <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h10);
    wr(OFF_XY, 32'h03);
    cnt_a <= 1'b0;
    wr(OFF_TX, 32'h1);
    wr(OFF_REQ, 32'h0);
    repeat (60) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h0);
    cnt_a <= 1'b1;
    repeat (60) @(posedge clk);
    rdc(OFF_REQ, 32'h10, 32'h10);
    finish_test();
  end
endmodule

`default_nettype wire
